// >>> adc_calibration_sequencer.v
// Calibration sequencer: mode field, output-rate timing, result-valid and data register
// How it works
// - After a calibration the block runs one normal conversion and then drives result_valid_n low.
// - When the calibration part of the sequence completes the mode field returns to normal operation.
// - The mode field clears strictly before result_valid_n falls, and clearing alone does not mark new data.
// - The wait to result_valid_n includes one conversion plus a scaling pipeline delay of at most 2000 clocks.
// - Self calibration (code 1) runs zero then full scale, clears the mode after 6 periods, valid after 9 plus delay.
// - System zero-scale calibration (code 2) clears the mode after 3 periods, valid after 4 plus delay.
// - System full-scale calibration (code 3) clears the mode after 3 periods, valid after 4 plus delay.
// - The latest conversion result is held in a read-only 16-bit data register.
`timescale 1ns/1ps
`include "cal_seq_map.vh"

module adc_calibration_sequencer
(
  // Clock and reset
  input  wire                   i_sys_clk,
  input  wire                   i_reset_n,
  // Mode write from the host
  input  wire                   i_mode_wr,
  input  wire [1:0]             i_mode,
  // Update-rate setting
  input  wire [1:0]             i_rate_sel,
  // Conversion result from the filter, one-cycle strobe
  input  wire                   i_conv_valid,
  input  wire [`RESULT_W-1:0]   i_conv_data,
  // Mode field and calibration phase
  output reg                    o_op_mode_hi,
  output reg                    o_op_mode_lo,
  output reg                    o_zero_scale,
  output reg                    o_full_scale,
  output reg                    o_cal_on_input,
  // Result
  output reg                    o_result_valid_n,
  output reg  [`RESULT_W-1:0]   o_data
);

  // State codes, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CAL  = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_PIPE = 4'h8;

  //--------------------------------------------------------------------------
  // Reset release
  //--------------------------------------------------------------------------
  reg        rst_meta_q;
  reg        rst_n_q;

  // Two-stage release of the asynchronous reset
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  //--------------------------------------------------------------------------
  // Output-rate period timer
  //--------------------------------------------------------------------------
  reg  [23:0] rate_clks;
  reg  [23:0] rate_cnt_q;
  wire        period_tick;

  // Period length from the update-rate code
  always @*
  begin
    case (i_rate_sel)
      2'h0:    rate_clks = `RATE0_CLKS;
      2'h1:    rate_clks = `RATE1_CLKS;
      2'h2:    rate_clks = `RATE2_CLKS;
      default: rate_clks = `RATE3_CLKS;
    endcase
  end

  assign period_tick = (rate_cnt_q >= rate_clks - 24'h000001);

  //--------------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------------
  reg  [3:0]  state_q;
  reg  [1:0]  mode_q;
  reg  [3:0]  per_cnt_q;
  reg  [3:0]  cal_len_q;
  reg  [3:0]  rdy_len_q;
  reg  [10:0] pipe_cnt_q;
  reg         start_cal;

  always @*
  begin
    // Only an idle block takes a write, so a refused write cannot restart the timer
    start_cal = i_mode_wr && (i_mode != `MODE_NORMAL) && (state_q == ST_IDLE);
  end

  // Main sequencing process
  always @(posedge i_sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q          <= ST_IDLE;
      mode_q           <= `MODE_NORMAL;
      per_cnt_q        <= 4'h0;
      cal_len_q        <= 4'h0;
      rdy_len_q        <= 4'h0;
      pipe_cnt_q       <= 11'h000;
      rate_cnt_q       <= 24'h000000;
      o_op_mode_hi     <= 1'b0;
      o_op_mode_lo     <= 1'b0;
      o_zero_scale     <= 1'b0;
      o_full_scale     <= 1'b0;
      o_cal_on_input   <= 1'b0;
      o_result_valid_n <= 1'b1;
      o_data           <= 16'h0000;
    end
    else
    begin
      // Free-running period timer, restarted with each calibration
      if (start_cal || period_tick)
        rate_cnt_q <= 24'h000000;
      else
        rate_cnt_q <= rate_cnt_q + 24'h000001;
      o_op_mode_hi <= mode_q[1];
      o_op_mode_lo <= mode_q[0];
      case (state_q)
        ST_IDLE:
        begin
          // Normal conversions update data and result-valid
          if (i_conv_valid)
          begin
            o_data           <= i_conv_data;
            o_result_valid_n <= 1'b0;
          end
          if (start_cal)
          begin
            mode_q           <= i_mode;
            o_op_mode_hi     <= i_mode[1];
            o_op_mode_lo     <= i_mode[0];
            per_cnt_q        <= 4'h0;
            o_result_valid_n <= 1'b1;
            o_cal_on_input   <= (i_mode != `MODE_SELF_CAL);
            o_zero_scale     <= (i_mode != `MODE_FS_SYS_CAL);
            o_full_scale     <= (i_mode == `MODE_FS_SYS_CAL);
            if (i_mode == `MODE_SELF_CAL)
            begin
              cal_len_q <= `SELF_CAL_PERIODS;
              rdy_len_q <= `SELF_RDY_PERIODS;
            end
            else
            begin
              cal_len_q <= `SYS_CAL_PERIODS;
              rdy_len_q <= `SYS_RDY_PERIODS;
            end
            state_q <= ST_CAL;
          end
        end
        ST_CAL:
        begin
          if (period_tick)
          begin
            per_cnt_q <= per_cnt_q + 4'h1;
            // Self calibration moves from zero to full scale halfway
            if (mode_q == `MODE_SELF_CAL && per_cnt_q == 4'h2)
            begin
              o_zero_scale <= 1'b0;
              o_full_scale <= 1'b1;
            end
            if (per_cnt_q + 4'h1 == cal_len_q)
            begin
              mode_q         <= `MODE_NORMAL;
              o_op_mode_hi   <= 1'b0;
              o_op_mode_lo   <= 1'b0;
              o_zero_scale   <= 1'b0;
              o_full_scale   <= 1'b0;
              o_cal_on_input <= 1'b0;
              state_q        <= ST_CONV;
            end
          end
        end
        ST_CONV:
        begin
          // One normal conversion after the calibration
          if (period_tick)
          begin
            per_cnt_q <= per_cnt_q + 4'h1;
            if (per_cnt_q + 4'h1 == rdy_len_q)
            begin
              pipe_cnt_q <= 11'h000;
              state_q    <= ST_PIPE;
            end
          end
          if (i_conv_valid)
            o_data <= i_conv_data;
        end
        ST_PIPE:
        begin
          // Scaling pipeline delay, then result valid
          if (pipe_cnt_q == `PIPE_DELAY_CLKS - 11'h001)
          begin
            o_result_valid_n <= 1'b0;
            state_q          <= ST_IDLE;
          end
          else
            pipe_cnt_q <= pipe_cnt_q + 11'h001;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // adc_calibration_sequencer

// >>> cal_seq_assertions.sv
// Port assertions for the calibration sequencer
`timescale 1ns/1ps
module cal_seq_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_mode_wr,
  input wire logic [1:0]  i_mode,
  input wire logic        i_conv_valid,
  input wire logic [15:0] i_conv_data,
  input wire logic        o_op_mode_hi,
  input wire logic        o_op_mode_lo,
  input wire logic        o_zero_scale,
  input wire logic        o_full_scale,
  input wire logic        o_cal_on_input,
  input wire logic        o_result_valid_n,
  input wire logic [15:0] o_data
);
  wire [1:0] md = {o_op_mode_hi, o_op_mode_lo};
  reg        seq_q;
  // Sequence in flight from mode shown until result valid
  always @(posedge i_sys_clk or negedge i_reset_n)
    if (!i_reset_n) seq_q <= 1'b0;
    else if (md != 2'h0) seq_q <= 1'b1;
    else if (!o_result_valid_n) seq_q <= 1'b0;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_start;
    i_mode_wr && i_mode != 2'h0 && !seq_q && md == 2'h0;
  endsequence
  a_mode_shows_code: assert property (s_start |=> md == $past(i_mode) && o_result_valid_n)
    else $error("mode field not loaded");
  a_clear_first: assert property ($fell(o_result_valid_n) |-> md == 2'h0)
    else $error("valid before mode cleared");
  a_valid_waits: assert property (seq_q && md != 2'h0 |-> o_result_valid_n)
    else $error("valid during calibration");
  a_zs_flags: assert property (md == 2'h2 |-> o_zero_scale && !o_full_scale && o_cal_on_input)
    else $error("zero-scale flags wrong");
  a_fs_flags: assert property (md == 2'h3 |-> o_full_scale && !o_zero_scale && o_cal_on_input)
    else $error("full-scale flags wrong");
  a_self_flags: assert property (md == 2'h1 |-> !o_cal_on_input && o_zero_scale != o_full_scale)
    else $error("self cal flags wrong");
  a_self_zs_first: assert property ($rose(md == 2'h1) |-> o_zero_scale)
    else $error("self cal not starting at zero");
  a_self_no_back: assert property (md == 2'h1 && o_full_scale |=> !o_zero_scale)
    else $error("self cal returned to zero");
  a_idle_flags: assert property (md == 2'h0 |-> !o_zero_scale && !o_full_scale && !o_cal_on_input)
    else $error("flags set in normal mode");
  a_data_capture: assert property (!seq_q && md == 2'h0 && i_conv_valid && !(i_mode_wr && i_mode != 2'h0)
    |=> o_data == $past(i_conv_data) && !o_result_valid_n)
    else $error("result not captured");
  a_valid_holds: assert property (!o_result_valid_n && !i_mode_wr |=> !o_result_valid_n)
    else $error("valid dropped");
endmodule // cal_seq_checker
bind adc_calibration_sequencer cal_seq_checker u_cal_seq_checker (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_mode_wr(i_mode_wr), .i_mode(i_mode), .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data),
  .o_op_mode_hi(o_op_mode_hi), .o_op_mode_lo(o_op_mode_lo), .o_zero_scale(o_zero_scale),
  .o_full_scale(o_full_scale), .o_cal_on_input(o_cal_on_input), .o_result_valid_n(o_result_valid_n),
  .o_data(o_data));

// >>> cal_seq_map.vh
// Constants for the calibration sequencer: mode codes, durations, timing counts
`ifndef CAL_SEQ_MAP_VH
`define CAL_SEQ_MAP_VH

// Two-bit operating mode codes
`define MODE_NORMAL        2'h0
`define MODE_SELF_CAL      2'h1
`define MODE_ZS_SYS_CAL    2'h2
`define MODE_FS_SYS_CAL    2'h3

// Durations in output-rate periods
`define SELF_CAL_PERIODS   4'h6
`define SELF_RDY_PERIODS   4'h9
`define SYS_CAL_PERIODS    4'h3
`define SYS_RDY_PERIODS    4'h4

// Scaling pipeline delay in master clock periods, at most 2000
`define PIPE_DELAY_CLKS    11'h7D0

// Master clock periods per output-rate period for each update-rate code
`define RATE0_CLKS         24'h00C000
`define RATE1_CLKS         24'h00A000
`define RATE2_CLKS         24'h002666
`define RATE3_CLKS         24'h001333

// Result width
`define RESULT_W           16

`endif

// >>> conv_source_model.sv
// Filter output model: one-cycle result strobes on request
`timescale 1ns/1ps
module conv_source_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_word,
  output logic             o_valid = 1'b0,
  output logic [15:0]      o_data = 16'h0000
);
  // Word is only meaningful with the strobe, so it toggles otherwise
  always @(posedge i_clk)
  begin
    o_valid <= #1 i_go;
    o_data  <= #1 i_go ? i_word : ~o_data;
  end
endmodule // conv_source_model

// >>> tb.sv
// Testbench for the calibration sequencer
`timescale 1ns/1ps
`include "cal_seq_map.vh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        go = 1'b0;
  logic [1:0]  rate = 2'h3;
  logic [15:0] word = 16'h0000;
  wire         cv, mhi, mlo, zs, fs, cin, rvn;
  wire  [15:0] cd, dat;
  integer      err_total = 0, n_tests = 0, seed = 31, n, e;
  initial forever #4 clk = ~clk;
  conv_source_model u_conv_source_model (.i_clk(clk), .i_go(go), .i_word(word), .o_valid(cv), .o_data(cd));
  adc_calibration_sequencer u_adc_calibration_sequencer (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_mode_wr(wr), .i_mode(mode), .i_rate_sel(rate), .i_conv_valid(cv), .i_conv_data(cd),
    .o_op_mode_hi(mhi), .o_op_mode_lo(mlo), .o_zero_scale(zs), .o_full_scale(fs),
    .o_cal_on_input(cin), .o_result_valid_n(rvn), .o_data(dat));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Expected clocks from start to mode clear or to result valid
  function integer exp_clks(input logic [1:0] m, input logic rdy);
    if (m == 2'h1) exp_clks = (rdy ? `SELF_RDY_PERIODS : `SELF_CAL_PERIODS) * `RATE3_CLKS;
    else exp_clks = (rdy ? `SYS_RDY_PERIODS : `SYS_CAL_PERIODS) * `RATE3_CLKS;
    // Zero-scale run spends its first period at rate code 2
    if (m == 2'h2) exp_clks = exp_clks + `RATE2_CLKS - `RATE3_CLKS;
    if (rdy) exp_clks = exp_clks + `PIPE_DELAY_CLKS;
  endfunction
  task grab;
    word = 16'($random(seed));
    go = 1'b1;
    @(posedge clk); #1 go = 1'b0;
    repeat (2) @(posedge clk);
    #1 check("data", dat, word);
    check("valid", rvn, 1'b0);
  endtask
  // One calibration, with a refused write on the cycle after the start
  task cal(input logic [1:0] m);
    @(posedge clk); #1 wr = 1'b1;
    mode = m;
    rate = (m == 2'h2) ? 2'h2 : 2'h3;
    @(posedge clk); #1 mode = (m == 2'h1) ? 2'h2 : 2'h1;
    check("mode", {mhi, mlo}, m);
    check("flags", {zs, fs, cin}, (m == 2'h1) ? 3'b100 : {m == 2'h2, m == 2'h3, 1'b1});
    @(posedge clk); #1 wr = 1'b0;
    check("refused", {mhi, mlo}, m);
    n = 2;
    while ({mhi, mlo} != 2'h0 && n < 60000)
    begin
      @(posedge clk); #1 n++;
      // Back to rate code 3 right after the first period has ended
      if (n == `RATE2_CLKS + 1) rate = 2'h3;
    end
    e = exp_clks(m, 1'b0);
    check("clear time", n - 1, e);
    check("early valid", rvn, 1'b1);
    while (rvn && n < 60000)
    begin
      @(posedge clk); #1 n++;
    end
    e = exp_clks(m, 1'b1);
    check("valid time", n - 1, e);
    grab;
  endtask
  initial
  begin
    // A clean run takes about 94,500 cycles
    #(8 * 99000) err_total++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 check("reset", {mhi, mlo, zs, fs, cin, rvn}, 6'b000001);
    wr = 1'b1;
    @(posedge clk); #1 wr = 1'b0;
    check("mode0", {mhi, mlo}, 2'h0);
    repeat (2) grab;
    for (int m = 1; m < 4; m++) cal(m[1:0]);
    tally_and_finish;
  end
endmodule // tb
